// ---- shared/result_hold_pkg.sv ----
// constants for the per-channel result holding logic
// assumes a 100 MHz converter clock and a 16-bit, two-channel result path
package result_hold_pkg;

	// result path shape
	localparam int RES_W       = 16;
	localparam int NCH         = 2;
	localparam int FIFO_DEPTH  = 8;

	// serial frame layout: status word, channel 0 word, channel 1 word
	localparam int FRAME_BITS  = 48;
	localparam int CH0_END_BIT = 31;
	localparam int CH1_END_BIT = 47;
	localparam int CNT_W       = 6;

	// status word fields
	localparam int FLAG0_BIT   = 0;
	localparam int FLAG1_BIT   = 1;

	// data-ready pulse width
	localparam int CLK_NS      = 10;
	localparam int PULSE_NS    = 40;
	localparam int PULSE_CYC   = (PULSE_NS + CLK_NS - 1) / CLK_NS;
	localparam int PCNT_W      = 4;

	// data-ready pin states
	typedef enum logic [3:0] {
		RDY_IDLE  = 4'h1,
		RDY_LOW   = 4'h2,
		RDY_BLIP  = 4'h4,
		RDY_PULSE = 4'h8
	} ready_state_e;

endpackage : result_hold_pkg

// ---- shared/result_stream_if.sv ----
// valid/ready word stream between the holding logic and its fifo
// assumes both ends run on the same clock
`timescale 1ns/1ns
interface result_stream_if #(parameter int W = 32);
	logic [W-1:0] data;
	logic         valid;
	logic         ready;

	modport src (output data, output valid, input ready);
	modport snk (input data, input valid, output ready);
endinterface : result_stream_if

// ---- hw/result_fifo.sv ----
// synchronous fifo of DEPTH words of WIDTH bits with valid/ready on both sides
// assumes one clock, an active-low async reset and a synchronous flush
`timescale 1ns/1ns
module result_fifo
	import result_hold_pkg::*;
#(
	parameter int WIDTH = 32,
	parameter int DEPTH = 8
)
(
	// clock and control
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic ce,
	input  wire logic flush,
	// streams
	result_stream_if.snk wr,
	result_stream_if.src rd
);
	localparam int PW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0]    wptr_reg;
	logic [PW-1:0]    rptr_reg;
	logic [CW-1:0]    count_reg;
	logic             push;
	logic             pop;

	function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
		if (p == PW'(DEPTH - 1))
			return '0;
		return p + PW'(1);
	endfunction : bump

	assign wr.ready = ce && !flush && (count_reg != FULL_CNT);
	assign rd.valid = (count_reg != '0);
	assign rd.data  = mem[rptr_reg];
	assign push     = wr.valid && wr.ready;
	assign pop      = rd.valid && rd.ready && ce && !flush;

	// storage
	always_ff @(posedge clk)
	begin
		if (push)
			mem[wptr_reg] <= wr.data;
	end

	// pointers and fill level
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wptr_reg  <= '0;
			rptr_reg  <= '0;
			count_reg <= '0;
		end
		else if (ce)
		begin
			if (flush)
			begin
				wptr_reg  <= '0;
				rptr_reg  <= '0;
				count_reg <= '0;
			end
			else
			begin
				if (push)
					wptr_reg <= bump(wptr_reg);
				if (pop)
					rptr_reg <= bump(rptr_reg);
				if (push && !pop)
					count_reg <= count_reg + CW'(1);
				else if (pop && !push)
					count_reg <= count_reg - CW'(1);
			end
		end
	end

endmodule : result_fifo

// ---- hw/result_hold.sv ----
// result holding logic: output and queue buffers per channel, data-ready pin, serial shift-out
// assumes results arrive on mclk; the serial port clock and chip select come from the host
//
// Behaviour
// - each channel keeps one output buffer and one queue buffer, one result each
// - serial output data always come from the queue buffer
// - every new result loads the output buffer as it leaves the input fifo, not while a frame shifts or a read lands
// - queue already read: new result loads queue together with output buffer
// - queue unread on one new result: keep old, take newer after it is read
// - queue unread over two new results: load latest, older two are lost
// - reading the queue leaves its content unless a newer result is pending; rereads then return the same result
// - level format: pin falls on new data, rises when all read or blips
// - pulse format: each result that reaches the queue unread gives a short low pulse
// - level format, missed read: pin stays low, blips high before next fall
// - pulse format, missed read: one pulse skipped, half rate without reads
// - a data read clears that channel's data-ready status flag unless a newer result is pending
// - sync/reset strobe restarts conversions and clears both buffers
// - level format: narrow blip after first read after a pause, host rereads
// - data frames carry the status word then both channel results
// - frame after a multi-register read carries no data, counts as no read
`timescale 1ns/1ns
module result_hold
	import result_hold_pkg::*;
#(
	parameter int W     = RES_W,
	parameter int DEPTH = FIFO_DEPTH
)
(
	// converter clock domain
	input  wire logic                mclk,
	input  wire logic                arst_n,
	input  wire logic                ce,
	// converter results, channel 1 in the upper half
	input  wire logic [NCH*W-1:0]    conv_data,
	input  wire logic                conv_valid,
	output logic                     conv_ready,
	output logic                     conv_restart,
	// configuration and status from the register logic
	input  wire logic                ready_format_select,
	input  wire logic [15:0]         status_in,
	// sync/reset pin
	input  wire logic                sync_reset_n,
	// data-ready pin
	output logic                     data_ready_pin,
	// serial port
	input  wire logic                sclk,
	input  wire logic                cs_n,
	input  wire logic                register_read_command,
	output logic                     dout,
	output logic                     dout_oe
);
	localparam int FW = FRAME_BITS;
	localparam logic [CNT_W-1:0] DATA_START = CNT_W'(FW - NCH*W);

	// streams through the input fifo
	result_stream_if #(.W(NCH*W)) in_s ();
	result_stream_if #(.W(NCH*W)) out_s ();

	// synchronisers
	logic             cs_s1_reg;
	logic             cs_s2_reg;
	logic             syn_s1_reg;
	logic             syn_s2_reg;
	logic             syn_s3_reg;
	logic [NCH-1:0]   rd_s1_reg;
	logic [NCH-1:0]   rd_s2_reg;
	logic [NCH-1:0]   rd_s3_reg;

	// channel buffers
	logic [W-1:0]     out_reg [NCH];
	logic [W-1:0]     queue_reg [NCH];
	logic [NCH-1:0]   read_reg;
	logic [NCH-1:0]   pend_reg;

	// pin state
	ready_state_e     state_reg;
	ready_state_e     state_next;
	logic [PCNT_W-1:0] pcnt_reg;
	logic             pin_reg;
	logic             restart_reg;

	// frame image and link side
	logic [FW-1:0]    snap_reg;
	logic [CNT_W-1:0] bit_cnt_reg;
	logic             no_data_reg;
	logic             no_data_now;
	logic [NCH-1:0]   rd_tgl_reg;
	logic             link_rst_n;

	// decoded events
	logic             frame_active;
	logic             sync_clear;
	logic [NCH-1:0]   rd_evt;
	logic             take;
	logic [NCH-1:0]   fresh;
	logic             fresh_any;
	logic             all_read;

	function automatic logic [W-1:0] chan_word(input logic [NCH*W-1:0] word, input int ch);
		return word[ch*W +: W];
	endfunction : chan_word

	// input fifo; its ready is the converter's back-pressure
	assign in_s.data  = conv_data;
	assign in_s.valid = conv_valid;
	assign conv_ready = in_s.ready;

	result_fifo #(.WIDTH(NCH*W), .DEPTH(DEPTH)) u_fifo (
		.clk   (mclk),
		.rst_n (arst_n),
		.ce    (ce),
		.flush (sync_clear),
		.wr    (in_s),
		.rd    (out_s)
	);

	// pin and link-event synchronisers
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			cs_s1_reg  <= 1'b1;
			cs_s2_reg  <= 1'b1;
			syn_s1_reg <= 1'b1;
			syn_s2_reg <= 1'b1;
			syn_s3_reg <= 1'b1;
			rd_s1_reg  <= '0;
			rd_s2_reg  <= '0;
			rd_s3_reg  <= '0;
		end
		else if (ce)
		begin
			cs_s1_reg  <= cs_n;
			cs_s2_reg  <= cs_s1_reg;
			syn_s1_reg <= sync_reset_n;
			syn_s2_reg <= syn_s1_reg;
			syn_s3_reg <= syn_s2_reg;
			rd_s1_reg  <= rd_tgl_reg;
			rd_s2_reg  <= rd_s1_reg;
			rd_s3_reg  <= rd_s2_reg;
		end
	end

	assign frame_active = !cs_s2_reg;
	assign sync_clear   = !syn_s2_reg;
	assign rd_evt       = rd_s2_reg ^ rd_s3_reg;

	// new results wait in the fifo while a frame is shifting or a read is landing
	assign out_s.ready = ce && !sync_clear && !frame_active && (rd_evt == '0);
	assign take        = out_s.valid && out_s.ready;

	// queue gets fresh unread data this cycle
	always_comb
	begin
		for (int ch = 0; ch < NCH; ch++)
			fresh[ch] = (take && (read_reg[ch] || pend_reg[ch])) || (rd_evt[ch] && pend_reg[ch]);
		fresh_any = |fresh;
		all_read  = &read_reg;
	end

	// channel buffers
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			for (int ch = 0; ch < NCH; ch++)
			begin
				out_reg[ch]   <= '0;
				queue_reg[ch] <= '0;
			end
			read_reg <= '1;
			pend_reg <= '0;
		end
		else if (ce)
		begin
			if (sync_clear)
			begin
				for (int ch = 0; ch < NCH; ch++)
				begin
					out_reg[ch]   <= '0;
					queue_reg[ch] <= '0;
				end
				read_reg <= '1;
				pend_reg <= '0;
			end
			else
			begin
				for (int ch = 0; ch < NCH; ch++)
				begin
					if (take)
					begin
						out_reg[ch] <= chan_word(out_s.data, ch);
						if (read_reg[ch])
						begin
							queue_reg[ch] <= chan_word(out_s.data, ch);
							read_reg[ch]  <= 1'b0;
						end
						else if (!pend_reg[ch])
							pend_reg[ch] <= 1'b1;
						else
						begin
							queue_reg[ch] <= chan_word(out_s.data, ch);
							pend_reg[ch]  <= 1'b0;
						end
					end
					else if (rd_evt[ch])
					begin
						// content stays unless a pending result moves in from the output buffer
						if (pend_reg[ch])
						begin
							queue_reg[ch] <= out_reg[ch];
							pend_reg[ch]  <= 1'b0;
						end
						else
							read_reg[ch] <= 1'b1;
					end
				end
			end
		end
	end

	// data-ready pin sequencing
	always_comb
	begin
		state_next = state_reg;
		unique case (state_reg)
			RDY_IDLE:
				if (fresh_any)
					state_next = ready_format_select ? RDY_PULSE : RDY_LOW;
			RDY_LOW:
				if (ready_format_select)
					state_next = RDY_IDLE;
				else if (fresh_any)
					state_next = RDY_BLIP;
				else if (all_read)
					state_next = RDY_IDLE;
			RDY_BLIP:
				if (pcnt_reg == PCNT_W'(PULSE_CYC - 1))
					state_next = RDY_LOW;
			RDY_PULSE:
				if (pcnt_reg == PCNT_W'(PULSE_CYC - 1))
					state_next = RDY_IDLE;
			default:
				state_next = RDY_IDLE;
		endcase
		if (sync_clear)
			state_next = RDY_IDLE;
	end

	// missed reads give no fresh event, so a pulse is skipped
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			state_reg <= RDY_IDLE;
			pcnt_reg  <= '0;
			pin_reg   <= 1'b1;
		end
		else if (ce)
		begin
			state_reg <= state_next;
			if (state_next != state_reg)
				pcnt_reg <= '0;
			else
				pcnt_reg <= pcnt_reg + PCNT_W'(1);
			pin_reg <= !(state_next == RDY_LOW || state_next == RDY_PULSE);
		end
	end

	assign data_ready_pin = pin_reg;

	// conversion restart on the sync/reset falling edge
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			restart_reg <= 1'b0;
		else if (ce)
			restart_reg <= syn_s3_reg && !syn_s2_reg;
	end

	assign conv_restart = restart_reg;

	// frame image, frozen while chip select is low
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			snap_reg <= '0;
		else if (ce && !frame_active)
			snap_reg <= {status_in[15:FLAG1_BIT+1], !read_reg[1], !read_reg[0],
				queue_reg[0], queue_reg[1]};
	end

	// link side: bit counter cleared by chip select high
	assign link_rst_n  = arst_n && !cs_n;
	assign no_data_now = (bit_cnt_reg == '0) ? register_read_command : no_data_reg;

	always_ff @(posedge sclk or negedge link_rst_n)
	begin
		if (!link_rst_n)
		begin
			bit_cnt_reg <= '0;
			no_data_reg <= 1'b0;
		end
		else
		begin
			if (bit_cnt_reg == '0)
				no_data_reg <= register_read_command;
			if (bit_cnt_reg != CNT_W'(FW))
				bit_cnt_reg <= bit_cnt_reg + CNT_W'(1);
		end
	end

	// read completion toggles, one per channel
	always_ff @(posedge sclk or negedge arst_n)
	begin
		if (!arst_n)
			rd_tgl_reg <= '0;
		else if (!no_data_now)
		begin
			if (bit_cnt_reg == CNT_W'(CH0_END_BIT))
				rd_tgl_reg[0] <= !rd_tgl_reg[0];
			if (bit_cnt_reg == CNT_W'(CH1_END_BIT))
				rd_tgl_reg[1] <= !rd_tgl_reg[1];
		end
	end

	// serial data, msb first
	// a no-data frame shows zero in place of the channel words
	assign dout    = (bit_cnt_reg < CNT_W'(FW) && !(no_data_now && bit_cnt_reg >= DATA_START))
		? snap_reg[CNT_W'(FW - 1) - bit_cnt_reg] : 1'b0;
	assign dout_oe = !cs_n;

endmodule : result_hold

// ---- test/result_hold_sva.sv ----
// checker for the result holding block, bound to its top
// assumes mclk and the active-low async reset arst_n
`timescale 1ns/1ns
module result_hold_sva
	import result_hold_pkg::*;
(
	// watched ports
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic ce,
	input wire logic conv_ready,
	input wire logic conv_restart,
	input wire logic ready_format_select,
	input wire logic sync_reset_n,
	input wire logic data_ready_pin,
	input wire logic cs_n,
	input wire logic dout_oe
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!arst_n);
	AST_OE: assert property (dout_oe == !cs_n)
		else $error("oe mismatch");
	AST_CE: assert property (!ce |-> !conv_ready)
		else $error("ready while halted");
	AST_HOLD: assert property (!ce |=> $stable(data_ready_pin))
		else $error("pin moved while halted");
	AST_SYNC: assert property (!sync_reset_n [*3] |-> !conv_ready)
		else $error("ready during sync");
	AST_RSW: assert property (conv_restart |=> !conv_restart)
		else $error("restart too long");
	AST_CLR: assert property (conv_restart |-> ##[0:2] data_ready_pin)
		else $error("pin not cleared");
	AST_REL: assert property ($rose(arst_n) |-> data_ready_pin)
		else $error("pin low after reset");
	AST_PW: assert property ($fell(data_ready_pin) && ready_format_select
		|-> !data_ready_pin [*4] ##1 data_ready_pin) else $error("bad pulse");
	C_PUL: cover property ($fell(data_ready_pin) && ready_format_select);
	C_LVL: cover property ($fell(data_ready_pin) && !ready_format_select);
	C_SYN: cover property (conv_restart);
endmodule : result_hold_sva
bind result_hold result_hold_sva result_hold_sva_i (.*);

// ---- test/host_model.sv ----
// host side serial controller issuing data read frames
// assumes the link idles with clock low and select high
`timescale 1ns/1ns
module host_model
(
	// serial port
	output logic      sclk,
	output logic      cs_n,
	output logic      register_read_command,
	input  wire logic dout
);
	initial
	begin
		sclk = 1'b0;
		cs_n = 1'b1;
		register_read_command = 1'b0;
	end
	// one frame of n clocks, msb first
	task automatic frame(input int n, input logic mr, output logic [47:0] img);
		img = '0;
		register_read_command = mr;
		#7 cs_n = 1'b0;
		#30;
		for (int i = 0; i < n; i++)
		begin
			img = {img[46:0], dout};
			#24 sclk = 1'b1;
			#24 sclk = 1'b0;
		end
		#30 cs_n = 1'b1;
		register_read_command = 1'b0;
		#40;
	endtask : frame
endmodule : host_model

// ---- test/result_hold_tb.sv ----
// bench for the result holding block with a host serial model
// assumes 100 MHz mclk and a 48 ns host serial clock
`timescale 1ns/1ns
module result_hold_tb
	import result_hold_pkg::*;
;
	logic        mclk = 1'b0;
	logic        arst_n = 1'b0;
	logic        ce = 1'b1;
	logic [31:0] cd = '0;
	logic        cv = 1'b0;
	logic        fmt = 1'b0;
	logic        sync_n = 1'b1;
	logic [15:0] st = 16'ha5c3;
	logic        cr, rs, pin, sclk, cs_n, rrc, dout, oe;
	logic [47:0] img;
	int          num_errors = 0;
	int          num_checks = 0;
	int          nf = 0;
	int          np = 0;
	int          nr = 0;
	always #5 mclk = ~mclk;
	result_hold result_hold_i (.mclk(mclk), .arst_n(arst_n), .ce(ce), .conv_data(cd),
		.conv_valid(cv), .conv_ready(cr), .conv_restart(rs), .ready_format_select(fmt),
		.status_in(st), .sync_reset_n(sync_n), .data_ready_pin(pin), .sclk(sclk),
		.cs_n(cs_n), .register_read_command(rrc), .dout(dout), .dout_oe(oe));
	host_model host_model_i (.sclk(sclk), .cs_n(cs_n), .register_read_command(rrc),
		.dout(dout));
	always @(negedge pin) nf++;
	always @(posedge pin) np++;
	always @(posedge rs) nr++;
	task automatic close_out();
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : close_out
	task automatic cmp(input logic [47:0] g, input logic [47:0] e);
		num_checks++;
		if (g !== e)
		begin
			num_errors++;
			$display("wrong value at %0t: %h %h", $time, g, e);
		end
	endtask : cmp
	task automatic pc(input logic v);
		cmp({47'h0, pin}, {47'h0, v});
	endtask : pc
	function automatic logic [47:0] ex(input logic [1:0] f, input logic [15:0] a);
		return {st[15:2], f, a, ~a};
	endfunction : ex
	task automatic push(input logic [15:0] a);
		int i;
		i = 0;
		@(negedge mclk);
		cd = {~a, a};
		cv = 1'b1;
		while (!cr && i < 50)
		begin
			@(negedge mclk);
			i++;
		end
		if (i == 50)
		begin
			num_errors++;
			close_out();
		end
		@(negedge mclk);
		cv = 1'b0;
		repeat (10) @(negedge mclk);
	endtask : push
	task automatic rd(input logic [47:0] e);
		host_model_i.frame(48, 1'b0, img);
		cmp(img, e);
		repeat (5) @(negedge mclk);
	endtask : rd
	task automatic t_level();
		push(16'h1234);
		pc(1'b0);
		ce = 1'b0;
		repeat (3) @(negedge mclk);
		ce = 1'b1;
		rd(ex(2'b11, 16'h1234));
		pc(1'b1);
		rd(ex(2'b00, 16'h1234));
		$display("level test done");
	endtask : t_level
	task automatic t_miss();
		push(16'h0b0b);
		push(16'h0c0c);
		pc(1'b0);
		np = 0;
		rd(ex(2'b11, 16'h0b0b));
		cmp(48'(np), 48'h2);
		rd(ex(2'b11, 16'h0c0c));
		push(16'h0d0d);
		push(16'h0e0e);
		push(16'h0f0f);
		rd(ex(2'b11, 16'h0f0f));
		pc(1'b1);
		push(16'h0a0a);
		host_model_i.frame(48, 1'b1, img);
		cmp(img, {st[15:2], 2'b11, 32'h0});
		host_model_i.frame(20, 1'b0, img);
		cmp(img, ex(2'b11, 16'h0a0a) >> 28);
		rd(ex(2'b11, 16'h0a0a));
		$display("missed read test done");
	endtask : t_miss
	task automatic t_pulse();
		@(negedge mclk);
		fmt = 1'b1;
		repeat (5) @(negedge mclk);
		nf = 0;
		push(16'h0101);
		cmp(48'(nf), 48'h1);
		rd(ex(2'b11, 16'h0101));
		nf = 0;
		push(16'h0202);
		push(16'h0303);
		push(16'h0404);
		cmp(48'(nf), 48'h2);
		rd(ex(2'b11, 16'h0404));
		$display("pulse test done");
	endtask : t_pulse
	task automatic t_sync();
		@(negedge mclk);
		fmt = 1'b0;
		push(16'h5555);
		pc(1'b0);
		nr = 0;
		sync_n = 1'b0;
		repeat (6) @(negedge mclk);
		sync_n = 1'b1;
		repeat (6) @(negedge mclk);
		pc(1'b1);
		cmp(48'(nr), 48'h1);
		rd({st[15:2], 34'h0});
		$display("sync test done");
	endtask : t_sync
	initial
	begin
		repeat (4) @(negedge mclk);
		arst_n = 1'b1;
		repeat (3) @(negedge mclk);
		t_level();
		t_miss();
		t_pulse();
		t_sync();
		close_out();
	end
	initial
	begin
		#500000;
		num_errors++;
		close_out();
	end
endmodule : result_hold_tb
